/* common/ccu_pkg.sv */
`default_nettype none
package ccu_pkg;
   // register bus geometry
   localparam int CCU_AW = 3;
   localparam int CCU_DW = 8;
   // register offsets
   localparam logic [CCU_AW-1:0] CCU_ADDR_CTRL = 3'h0;
   localparam logic [CCU_AW-1:0] CCU_ADDR_DIDR = 3'h1;
   localparam logic [CCU_AW-1:0] CCU_ADDR_MUX = 3'h2;
   localparam logic [CCU_AW-1:0] CCU_ADDR_ISTAT = 3'h3;
   localparam logic [CCU_AW-1:0] CCU_ADDR_IMASK = 3'h4;
   // comparator_control_status fields
   localparam int CCU_BIT_PWR_OFF = 7;
   localparam int CCU_BIT_BANDGAP = 6;
   localparam int CCU_BIT_RESULT = 5;
   localparam int CCU_BIT_FLAG = 4;
   localparam int CCU_BIT_IRQ_EN = 3;
   localparam int CCU_BIT_CAPTURE = 2;
   localparam int CCU_BIT_MODE_HI = 1;
   localparam int CCU_BIT_MODE_LO = 0;
   // comparator_pin_input_disable fields
   localparam int CCU_BIT_NEG_OFF = 1;
   localparam int CCU_BIT_POS_OFF = 0;
   // negative input mux register fields
   localparam int CCU_BIT_MUX_EN = 6;
   localparam int CCU_CH_W = 3;
   // interrupt status / mask fields
   localparam int CCU_IW = 2;
   localparam int CCU_IST_EVENT = 0;
   localparam int CCU_IST_CHANGE = 1;
   // reset values
   localparam logic [CCU_DW-1:0] CCU_CTRL_RST = 8'h00;
   localparam logic [CCU_DW-1:0] CCU_DIDR_RST = 8'h00;
   localparam logic [CCU_DW-1:0] CCU_MUX_RST = 8'h00;
   localparam logic [CCU_IW-1:0] CCU_IMASK_RST = 2'h0;
   // synchroniser depth: result lags the raw output by two cycles
   localparam int CCU_SYNC_STAGES = 2;
   // flag-setting event modes
   typedef enum logic [1:0] {
      CCU_EV_TOGGLE = 2'b00,
      CCU_EV_RSVD = 2'b01,
      CCU_EV_FALL = 2'b10,
      CCU_EV_RISE = 2'b11
   } ccu_evmode_t;
endpackage
`default_nettype wire

/* hdl/ccu_sync.sv */
`default_nettype none
module ccu_sync #(
   parameter int STAGES = ccu_pkg::CCU_SYNC_STAGES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d_in,
   output logic q_out
);
   import ccu_pkg::*;
   typedef struct packed {
      logic [STAGES-1:0] sh;
   } ccu_sync_st_t;
   ccu_sync_st_t st_ff, nxt_st;

   // fewer than two stages would let metastability reach the logic
   if (STAGES < 2)
   begin : g_chk
      $error("ccu_sync needs at least two stages");
   end

   // shift chain; only the last stage is read outside
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.sh = {st_ff.sh[STAGES-2:0], d_in};
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign q_out = st_ff.sh[STAGES-1];
endmodule // ccu_sync
`default_nettype wire

/* hdl/ccu_edge.sv */
`default_nettype none
module ccu_edge (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cur,
   input wire logic hold,
   input wire ccu_pkg::ccu_evmode_t mode,
   output logic event_hit,
   output logic changed
);
   import ccu_pkg::*;
   typedef struct packed {
      logic prev;
   } ccu_edge_st_t;
   ccu_edge_st_t st_ff, nxt_st;
   logic rise;
   logic fall;

   // previous value always follows, so a change made while held is
   // swallowed rather than fired later
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.prev = cur;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   // compare with the last cycle's value
   assign rise = cur & ~st_ff.prev;
   assign fall = ~cur & st_ff.prev;
   assign changed = (rise | fall) & ~hold;

   // mode decode, reserved code never fires
   always_comb
   begin
      case (mode)
         CCU_EV_TOGGLE: event_hit = rise | fall;
         CCU_EV_FALL: event_hit = fall;
         CCU_EV_RISE: event_hit = rise;
         CCU_EV_RSVD: event_hit = 1'b0;
         default: event_hit = 1'b0;
      endcase
      event_hit = event_hit & ~hold;
   end
endmodule // ccu_edge
`default_nettype wire

/* hdl/ccu_top.sv */
`default_nettype none
module ccu_top (
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   input wire logic [ccu_pkg::CCU_AW-1:0] ADDR,
   input wire logic [ccu_pkg::CCU_DW-1:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [ccu_pkg::CCU_DW-1:0] RDATA,
   input wire logic COMP_RAW,
   input wire logic CONVERTER_ENABLE,
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic VECTOR_ACK,
   input wire logic POS_PIN_RAW,
   input wire logic NEG_PIN_RAW,
   output logic COMP_POWER_OFF,
   output logic BANDGAP_SELECT,
   output logic COMP_RESULT,
   output logic NEG_USE_CHANNEL,
   output logic [ccu_pkg::CCU_CH_W-1:0] NEG_CHANNEL,
   output logic CAPTURE_ROUTE,
   output logic CAPTURE_INPUT,
   output logic POS_BUFFER_OFF,
   output logic NEG_BUFFER_OFF,
   output logic POS_PIN_DATA,
   output logic NEG_PIN_DATA,
   output logic COMP_IRQ_REQ,
   output logic IRQ
);
   import ccu_pkg::*;

   typedef struct packed {
      logic pwr_off;
      logic bandgap;
      logic flag;
      logic irq_en;
      logic capture;
      ccu_evmode_t mode;
      logic neg_off;
      logic pos_off;
      logic mux_en;
      logic [CCU_CH_W-1:0] chsel;
      logic [CCU_IW-1:0] istat;
      logic [CCU_IW-1:0] imask;
      logic [CCU_DW-1:0] rdata;
   } ccu_st_t;

   ccu_st_t st_ff, nxt_st;
   logic result;
   logic ev_hit;
   logic ev_change;
   logic wr_ctrl;
   logic wr_didr;
   logic wr_mux;
   logic wr_imask;
   logic rd_istat;
   logic [CCU_DW-1:0] ctrl_view;
   logic [CCU_DW-1:0] rd_mux;

   // raw output crosses into the core clock through two flops
   ccu_sync #(
      .STAGES(CCU_SYNC_STAGES)
   ) u_sync (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .d_in(COMP_RAW),
      .q_out(result)
   );

   // event detection, held quiet while the comparator is unpowered
   ccu_edge u_edge (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .cur(result),
      .hold(st_ff.pwr_off),
      .mode(st_ff.mode),
      .event_hit(ev_hit),
      .changed(ev_change)
   );

   // address decode
   assign wr_ctrl = WR_STB && (ADDR == CCU_ADDR_CTRL);
   assign wr_didr = WR_STB && (ADDR == CCU_ADDR_DIDR);
   assign wr_mux = WR_STB && (ADDR == CCU_ADDR_MUX);
   assign wr_imask = WR_STB && (ADDR == CCU_ADDR_IMASK);
   assign rd_istat = RD_STB && (ADDR == CCU_ADDR_ISTAT);

   // readable image of the control/status register
   always_comb
   begin
      ctrl_view = '0;
      ctrl_view[CCU_BIT_PWR_OFF] = st_ff.pwr_off;
      ctrl_view[CCU_BIT_BANDGAP] = st_ff.bandgap;
      ctrl_view[CCU_BIT_RESULT] = result;
      ctrl_view[CCU_BIT_FLAG] = st_ff.flag;
      ctrl_view[CCU_BIT_IRQ_EN] = st_ff.irq_en;
      ctrl_view[CCU_BIT_CAPTURE] = st_ff.capture;
      ctrl_view[CCU_BIT_MODE_HI:CCU_BIT_MODE_LO] = st_ff.mode;
      rd_mux = '0;
      rd_mux[CCU_BIT_MUX_EN] = st_ff.mux_en;
      rd_mux[CCU_CH_W-1:0] = st_ff.chsel;
   end

   // next-state: register writes, flag, sticky status, read data
   always_comb
   begin
      nxt_st = st_ff;
      // control/status writes; result bit is not writable
      if (wr_ctrl)
      begin
         nxt_st.pwr_off = WDATA[CCU_BIT_PWR_OFF];
         nxt_st.bandgap = WDATA[CCU_BIT_BANDGAP];
         nxt_st.irq_en = WDATA[CCU_BIT_IRQ_EN];
         nxt_st.capture = WDATA[CCU_BIT_CAPTURE];
         nxt_st.mode =
            ccu_evmode_t'(WDATA[CCU_BIT_MODE_HI:CCU_BIT_MODE_LO]);
      end
      // only two bits exist, the rest is dropped
      if (wr_didr)
      begin
         nxt_st.neg_off = WDATA[CCU_BIT_NEG_OFF];
         nxt_st.pos_off = WDATA[CCU_BIT_POS_OFF];
      end
      if (wr_mux)
      begin
         nxt_st.mux_en = WDATA[CCU_BIT_MUX_EN];
         nxt_st.chsel = WDATA[CCU_CH_W-1:0];
      end
      if (wr_imask)
         nxt_st.imask = WDATA[CCU_IW-1:0];
      // flag: vector or written one clears, a new event wins
      if (VECTOR_ACK || (wr_ctrl && WDATA[CCU_BIT_FLAG]))
         nxt_st.flag = 1'b0;
      if (ev_hit)
         nxt_st.flag = 1'b1;
      // sticky status, cleared by reading; set in same cycle wins
      if (rd_istat)
         nxt_st.istat = '0;
      if (ev_hit)
         nxt_st.istat[CCU_IST_EVENT] = 1'b1;
      if (ev_change)
         nxt_st.istat[CCU_IST_CHANGE] = 1'b1;
      // read data valid only in the cycle after the strobe
      nxt_st.rdata = '0;
      if (RD_STB)
      begin
         case (ADDR)
            CCU_ADDR_CTRL: nxt_st.rdata = ctrl_view;
            CCU_ADDR_DIDR: nxt_st.rdata =
               {6'h00, st_ff.neg_off, st_ff.pos_off};
            CCU_ADDR_MUX: nxt_st.rdata = rd_mux;
            CCU_ADDR_ISTAT: nxt_st.rdata = {6'h00, st_ff.istat};
            CCU_ADDR_IMASK: nxt_st.rdata = {6'h00, st_ff.imask};
            default: nxt_st.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         st_ff <= '0;
         st_ff.pwr_off <= CCU_CTRL_RST[CCU_BIT_PWR_OFF];
         st_ff.bandgap <= CCU_CTRL_RST[CCU_BIT_BANDGAP];
         st_ff.flag <= CCU_CTRL_RST[CCU_BIT_FLAG];
         st_ff.irq_en <= CCU_CTRL_RST[CCU_BIT_IRQ_EN];
         st_ff.capture <= CCU_CTRL_RST[CCU_BIT_CAPTURE];
         st_ff.mode <= ccu_evmode_t'(
            CCU_CTRL_RST[CCU_BIT_MODE_HI:CCU_BIT_MODE_LO]);
         st_ff.neg_off <= CCU_DIDR_RST[CCU_BIT_NEG_OFF];
         st_ff.pos_off <= CCU_DIDR_RST[CCU_BIT_POS_OFF];
         st_ff.mux_en <= CCU_MUX_RST[CCU_BIT_MUX_EN];
         st_ff.chsel <= CCU_MUX_RST[CCU_CH_W-1:0];
         st_ff.imask <= CCU_IMASK_RST;
      end
      else
         st_ff <= nxt_st;
   end

   // analog controls straight from the registers
   assign COMP_POWER_OFF = st_ff.pwr_off;
   assign BANDGAP_SELECT = st_ff.bandgap;
   assign COMP_RESULT = result;

   // negative input: converter must be off to borrow its mux
   assign NEG_USE_CHANNEL = st_ff.mux_en & ~CONVERTER_ENABLE;
   assign NEG_CHANNEL = NEG_USE_CHANNEL ? st_ff.chsel : '0;

   // capture path uses the synchronised result; the timer does its
   // own noise cancelling and edge choice
   assign CAPTURE_ROUTE = st_ff.capture;
   assign CAPTURE_INPUT = st_ff.capture & result;

   // digital input buffers; a disabled pin reads zero
   assign POS_BUFFER_OFF = st_ff.pos_off;
   assign NEG_BUFFER_OFF = st_ff.neg_off;
   assign POS_PIN_DATA = POS_PIN_RAW & ~st_ff.pos_off;
   assign NEG_PIN_DATA = NEG_PIN_RAW & ~st_ff.neg_off;

   // core request; software must mask it around mode or power changes
   assign COMP_IRQ_REQ =
      st_ff.flag & st_ff.irq_en & GLOBAL_IRQ_ENABLE;
   assign IRQ = |(st_ff.istat & st_ff.imask);
   assign RDATA = st_ff.rdata;

   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESET_N);

   sequence s_wr_ctrl;
      WR_STB && (ADDR == CCU_ADDR_CTRL);
   endsequence

   sequence s_rd(logic [CCU_AW-1:0] a);
      RD_STB && (ADDR == a);
   endsequence

   sequence s_event;
      ev_hit;
   endsequence

   AST_PWR_WRITE: assert property (
      s_wr_ctrl |=> COMP_POWER_OFF == $past(WDATA[CCU_BIT_PWR_OFF]))
      else $error("power-off bit did not follow write");

   AST_BG_HOLD: assert property (
      !(WR_STB && (ADDR == CCU_ADDR_CTRL)) |=> $stable(BANDGAP_SELECT))
      else $error("bandgap select moved without write");

   AST_SYNC_LAT: assert property (
      ##2 COMP_RESULT == $past(COMP_RAW, 2))
      else $error("result not two cycles behind raw output");

   AST_RESULT_READ: assert property (
      s_rd(CCU_ADDR_CTRL) |=> RDATA[CCU_BIT_RESULT] == $past(COMP_RESULT))
      else $error("result bit read wrong");

   AST_FLAG_SET: assert property (
      s_event |=> st_ff.flag)
      else $error("event did not set flag");

   AST_REQ_GATE: assert property (
      COMP_IRQ_REQ |-> st_ff.flag && st_ff.irq_en && GLOBAL_IRQ_ENABLE)
      else $error("request without flag and enables");

   // an event seen with the enable on must reach the core gate
   AST_REQ_EVENT: assert property (
      s_event ##1 st_ff.irq_en |-> COMP_IRQ_REQ == GLOBAL_IRQ_ENABLE)
      else $error("event did not reach request gate");

   AST_FLAG_CLR: assert property (
      (VECTOR_ACK || (wr_ctrl && WDATA[CCU_BIT_FLAG])) && !ev_hit
      |=> !st_ff.flag)
      else $error("flag not cleared");

   AST_FLAG_ZERO_WR: assert property (
      s_wr_ctrl and !WDATA[CCU_BIT_FLAG] and !VECTOR_ACK
      |=> st_ff.flag == ($past(st_ff.flag) || $past(ev_hit)))
      else $error("writing zero changed flag");

   AST_CAP_OFF: assert property (
      !CAPTURE_ROUTE |-> !CAPTURE_INPUT)
      else $error("capture input driven while unrouted");

   AST_MODE_RSVD: assert property (
      st_ff.mode == CCU_EV_RSVD |=> !st_ff.flag || $past(st_ff.flag))
      else $error("reserved mode set the flag");

   AST_MODE_RISE: assert property (
      st_ff.mode == CCU_EV_RISE && !st_ff.pwr_off && $rose(result)
      |-> ev_hit)
      else $error("rising edge missed");

   AST_NEG_PIN: assert property (
      (!st_ff.mux_en || CONVERTER_ENABLE) |-> !NEG_USE_CHANNEL)
      else $error("mux used while it should not be");

   AST_NEG_MUX: assert property (
      s_rd(CCU_ADDR_MUX) ##0 NEG_USE_CHANNEL
      |=> RDATA[CCU_CH_W-1:0] == $past(NEG_CHANNEL))
      else $error("channel select mismatch");

   AST_PIN_ZERO: assert property (
      POS_BUFFER_OFF |-> !POS_PIN_DATA)
      else $error("disabled pin reads one");

   AST_DIDR_RSV: assert property (
      s_rd(CCU_ADDR_DIDR) |=> RDATA[CCU_DW-1:2] == '0)
      else $error("reserved bits read nonzero");

   AST_OFF_QUIET: assert property (
      st_ff.pwr_off [*2] |-> !ev_hit && !ev_change)
      else $error("event while powered off");

   AST_EDGE_PREV: assert property (
      ev_change |-> result != $past(result))
      else $error("change flagged without edge");
endmodule // ccu_top
`default_nettype wire

/* verif/ccu_comp_model.sv */
`default_nettype none
module ccu_comp_model (
   input wire logic clk,
   input wire logic power_off,
   input wire logic bandgap_sel,
   input wire logic neg_use_channel,
   input wire logic [ccu_pkg::CCU_CH_W-1:0] neg_channel,
   input wire logic slow,
   input wire logic [7:0] v_pos,
   input wire logic [63:0] v_ch,
   output logic comp_raw
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] BG_LEVEL = 8'hf0;
   localparam logic [7:0] NEG_LEVEL = 8'h80;
   logic [7:0] pos_in;
   logic [7:0] neg_in;
   logic fast_q = 1'b0;
   logic slow_q = 1'b0;
   // analog input selection follows the block's select lines
   assign pos_in = bandgap_sel ? BG_LEVEL : v_pos;
   assign neg_in =
      neg_use_channel ? v_ch[8*neg_channel +: 8] : NEG_LEVEL;
   // unpowered output is junk: toggle so a leaky event gate shows up
   always @(posedge clk)
   begin
      fast_q <= power_off ? ~fast_q : (pos_in > neg_in);
      slow_q <= fast_q;
   end
   // slow mode adds one cycle of analog settling
   assign comp_raw = slow ? slow_q : fast_q;
endmodule // ccu_comp_model
`default_nettype wire

/* verif/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import ccu_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [CCU_AW-1:0] addr = '0;
   logic [CCU_DW-1:0] wdata = '0;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [CCU_DW-1:0] rdata;
   logic comp_raw, conv_en = 1'b0, gie = 1'b0, vec_ack = 1'b0;
   logic pos_raw = 1'b1, neg_raw = 1'b1;
   logic pwr_off, bg_sel, result, use_ch, cap_route, cap_in;
   logic pos_off, neg_off, pos_data, neg_data, irq_req, irq;
   logic [CCU_CH_W-1:0] neg_ch;
   logic slow = 1'b0;
   logic [7:0] v_pos = 8'h20;
   logic [63:0] v_ch = '0;
   logic [7:0] exp_q[$];
   logic rd_d = 1'b0;
   logic en, use_exp;
   logic [7:0] lvl;
   logic [7:0] exp_v;
   int n_mismatch = 0;
   int comparisons = 0;

   ccu_top dut_u (
      .CORE_CLK(clk), .RESET_N(rst_n), .ADDR(addr), .WDATA(wdata),
      .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
      .COMP_RAW(comp_raw), .CONVERTER_ENABLE(conv_en),
      .GLOBAL_IRQ_ENABLE(gie), .VECTOR_ACK(vec_ack),
      .POS_PIN_RAW(pos_raw), .NEG_PIN_RAW(neg_raw),
      .COMP_POWER_OFF(pwr_off), .BANDGAP_SELECT(bg_sel),
      .COMP_RESULT(result), .NEG_USE_CHANNEL(use_ch),
      .NEG_CHANNEL(neg_ch), .CAPTURE_ROUTE(cap_route),
      .CAPTURE_INPUT(cap_in), .POS_BUFFER_OFF(pos_off),
      .NEG_BUFFER_OFF(neg_off), .POS_PIN_DATA(pos_data),
      .NEG_PIN_DATA(neg_data), .COMP_IRQ_REQ(irq_req), .IRQ(irq)
   );

   ccu_comp_model model_u (
      .clk(clk), .power_off(pwr_off), .bandgap_sel(bg_sel),
      .neg_use_channel(use_ch), .neg_channel(neg_ch), .slow(slow),
      .v_pos(v_pos), .v_ch(v_ch), .comp_raw(comp_raw)
   );

   // free-running core clock
   initial
   begin
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
   begin
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   end
   endtask

   task automatic end_sim;
   begin
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   end
   endtask

   // one-cycle bus cycles; strobes drop at the sampling edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
   begin
      @(posedge clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_stb <= 1'b0;
   end
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] e);
   begin
      @(posedge clk);
      rd_stb <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      rd_stb <= 1'b0;
   end
   endtask

   task automatic idle(input int n);
   begin
      repeat (n) @(posedge clk);
      #1;
   end
   endtask

   task automatic cmp(input logic b);
   begin
      @(posedge clk);
      v_pos <= b ? 8'hc0 : 8'h20;
   end
   endtask

   // read data stands only in the cycle after the strobe
   always @(posedge clk)
   begin
      if (rd_d)
         chk(rdata, exp_q.pop_front());
      rd_d <= rd_stb;
   end

   // hang guard
   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      end_sim();
   end

   initial
   begin
      void'($urandom(32'h6ce4));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      // reset images, read-only result, unmapped space
      rd(CCU_ADDR_CTRL, 8'h00);
      rd(CCU_ADDR_DIDR, 8'h00);
      rd(CCU_ADDR_MUX, 8'h00);
      rd(CCU_ADDR_ISTAT, 8'h00);
      rd(CCU_ADDR_IMASK, 8'h00);
      wr(CCU_ADDR_CTRL, 8'h20);
      rd(CCU_ADDR_CTRL, 8'h00);
      wr(3'h6, 8'hff);
      rd(3'h6, 8'h00);
      $display("reset test done");
      // pin buffer disables
      wr(CCU_ADDR_DIDR, 8'hff);
      rd(CCU_ADDR_DIDR, 8'h03);
      idle(1);
      chk(8'({pos_off, neg_off, pos_data, neg_data}), 8'h0c);
      wr(CCU_ADDR_DIDR, 8'h02);
      idle(1);
      chk(8'({pos_off, neg_off, pos_data, neg_data}), 8'h06);
      $display("pin test done");
      // every event mode, rise then fall, fast and slow comparator
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clk) slow <= m[0];
         // enable stays off while the mode changes
         wr(CCU_ADDR_CTRL, 8'(m));
         cmp(1'b1);
         idle(6);
         exp_v = (m == 0 || m == 3) ? 8'h30 : 8'h20;
         rd(CCU_ADDR_CTRL, exp_v | 8'(m));
         wr(CCU_ADDR_CTRL, 8'h10 | 8'(m));
         cmp(1'b0);
         idle(6);
         exp_v = (m == 0 || m == 2) ? 8'h10 : 8'h00;
         rd(CCU_ADDR_CTRL, exp_v | 8'(m));
         wr(CCU_ADDR_CTRL, 8'h10 | 8'(m));
      end
      $display("mode test done");
      // request gating, clearing, status and mask
      rd(CCU_ADDR_ISTAT, 8'h03);
      rd(CCU_ADDR_ISTAT, 8'h00);
      wr(CCU_ADDR_IMASK, 8'h01);
      wr(CCU_ADDR_CTRL, 8'h0b);
      cmp(1'b1);
      idle(6);
      chk(8'({irq, irq_req}), 8'h02);
      @(posedge clk) gie <= 1'b1;
      idle(1);
      chk(8'(irq_req), 8'h01);
      wr(CCU_ADDR_CTRL, 8'h0b);
      rd(CCU_ADDR_CTRL, 8'h3b);
      @(posedge clk) vec_ack <= 1'b1;
      @(posedge clk) vec_ack <= 1'b0;
      idle(1);
      chk(8'(irq_req), 8'h00);
      rd(CCU_ADDR_CTRL, 8'h2b);
      rd(CCU_ADDR_ISTAT, 8'h03);
      idle(1);
      chk(8'(irq), 8'h00);
      $display("interrupt test done");
      // powered-off comparator raises no events; enable dropped first
      wr(CCU_ADDR_CTRL, 8'h00);
      wr(CCU_ADDR_CTRL, 8'h80);
      idle(1);
      chk(8'(pwr_off), 8'h01);
      idle(20);
      rd(CCU_ADDR_ISTAT, 8'h00);
      $display("power test done");
      // bandgap on positive input and capture routing
      // timer side would also need its capture interrupt enabled
      wr(CCU_ADDR_CTRL, 8'h44);
      idle(8);
      chk(8'({pwr_off, bg_sel, cap_route, result, cap_in}), 8'h0f);
      wr(CCU_ADDR_CTRL, 8'h40);
      idle(1);
      chk(8'({cap_route, cap_in, result}), 8'h01);
      $display("capture test done");
      // negative input mux against random converter state
      wr(CCU_ADDR_CTRL, 8'h00);
      @(posedge clk) v_pos <= 8'h80;
      for (int i = 0; i < 8; i++)
      begin
         en = 1'($urandom);
         @(posedge clk);
         conv_en <= 1'($urandom);
         v_ch <= {$urandom, $urandom};
         wr(CCU_ADDR_MUX, {1'b0, en, 3'h0, 3'(i)});
         idle(6);
         use_exp = en & ~conv_en;
         lvl = use_exp ? v_ch[8*i +: 8] : 8'h80;
         exp_v = 8'({use_exp, use_exp ? 3'(i) : 3'h0});
         chk(8'({use_ch, neg_ch}), exp_v);
         chk(8'(result), 8'(lvl < 8'h80));
         rd(CCU_ADDR_MUX, {1'b0, en, 3'h0, 3'(i)});
      end
      idle(2);
      $display("mux test done");
      end_sim();
   end
endmodule // testbench
`default_nettype wire
